// ---- fault_flag_bits.sv ----
/*
 * Group of sticky status flags: hardware sets, software writes.
 * Assumes set pulses and writes come from the system clock domain.
 */
module fault_flag_bits #(
    parameter int WIDTH = 2
) (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_in,
    // Hardware events
    input wire logic [WIDTH-1:0] set_in,
    // Software write
    input wire logic wr_in,
    input wire logic [WIDTH-1:0] wr_val_in,
    // Flag state
    output logic [WIDTH-1:0] flags_out
);

    // A set in the write cycle wins so no event is lost
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            flags_out <= '0;
        end else if (wr_in) begin
            flags_out <= wr_val_in | set_in;
        end else begin
            flags_out <= flags_out | set_in;
        end
    end

endmodule

// ---- pipe_desc_pkg.sv ----
/*
 * Constants for the host pipe descriptor block: byte offsets, field
 * positions, reset values and the pipe size codes.
 * Assumes a byte-addressed descriptor window of 32 bytes per pipe.
 */
// Notes on behaviour
// - Auto_zero_len_handshake bit makes hardware send OUT ZLP
// - Size code selects maximum packet length
// - USB reset clears the pipe size field
// - IN multi-packet field accumulates moved bytes
// - Byte count tracks last or next transaction
// - Extended token sends variable and subtype
// - NAK, overrun or underflow sets flow fault
// - Isochronous IN CRC error sets bank flag
// - Pipe freezes when tally reaches error limit
// - Tokens carry device address and endpoint
// - Three-bit tally counts pipe errors
// - IN data CRC16 mismatch sets flag
// - Missing response sets timeout flag
// - Bad packet identifier sets flag
// - Bad data packet identifier sets flag
// - Toggle mismatch sets status bit 0
package pipe_desc_pkg;

    // Byte offsets inside the descriptor window
    localparam logic [4:0] OFS_PCK_BANK0 = 5'h04;
    localparam logic [4:0] OFS_PCK_BANK1 = 5'h14;
    localparam logic [4:0] OFS_EXT = 5'h08;
    localparam logic [4:0] OFS_BSTAT_BANK0 = 5'h0A;
    localparam logic [4:0] OFS_BSTAT_BANK1 = 5'h1A;
    localparam logic [4:0] OFS_CTRL = 5'h0C;
    localparam logic [4:0] OFS_PSTAT = 5'h0E;

    // Packet size word fields
    localparam int AZLP_BIT = 31;
    localparam int SIZE_LSB = 28;
    localparam int MPS_LSB = 14;
    localparam int BCNT_LSB = 0;

    // Extended token word fields
    localparam int SUBTYPE_LSB = 0;
    localparam int VAR_LSB = 4;

    // Control word fields
    localparam int ADDR_LSB = 0;
    localparam int EP_LSB = 8;
    localparam int LIMIT_LSB = 12;

    // Bank status bits
    localparam int FLOW_BIT = 1;
    localparam int BCRC_BIT = 0;

    // Pipe status bits
    localparam int TOGGLE_BIT = 0;
    localparam int DPID_BIT = 1;
    localparam int PID_BIT = 2;
    localparam int TOUT_BIT = 3;
    localparam int CRC16_BIT = 4;
    localparam int TALLY_LSB = 5;

    // Values after reset and the tally maximum
    localparam logic [31:0] PCK_RST = 32'h0000_0000;
    localparam logic [14:0] EXT_RST = 15'h0000;
    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam logic [2:0] TALLY_MAX = 3'h7;

    // Pipe size codes
    typedef enum logic [2:0] {
        SZ_8 = 3'h0,
        SZ_16 = 3'h1,
        SZ_32 = 3'h2,
        SZ_64 = 3'h3,
        SZ_128 = 3'h4,
        SZ_256 = 3'h5,
        SZ_512 = 3'h6,
        SZ_1023 = 3'h7
    } size_code_t;

endpackage

// ---- pipe_size_decode.sv ----
/*
 * Turns the 3-bit pipe size code into a registered maximum packet length.
 * Assumes full-speed operation, so the top code means 1023 bytes.
 */
module pipe_size_decode (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_in,
    // Size code
    input wire logic [2:0] size_code_in,
    // Maximum packet length in bytes
    output logic [10:0] max_len_out
);

    // Registered so the engine sees a clean value
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            max_len_out <= 11'h008;
        end else begin
            unique case (pipe_desc_pkg::size_code_t'(size_code_in))
                pipe_desc_pkg::SZ_8: max_len_out <= 11'h008;
                pipe_desc_pkg::SZ_16: max_len_out <= 11'h010;
                pipe_desc_pkg::SZ_32: max_len_out <= 11'h020;
                pipe_desc_pkg::SZ_64: max_len_out <= 11'h040;
                pipe_desc_pkg::SZ_128: max_len_out <= 11'h080;
                pipe_desc_pkg::SZ_256: max_len_out <= 11'h100;
                pipe_desc_pkg::SZ_512: max_len_out <= 11'h200;
                pipe_desc_pkg::SZ_1023: max_len_out <= 11'h3FF;
            endcase
        end
    end

endmodule

// ---- test_usb_host_pipe_descriptor.sv ----
/*
 * Self-checking bench for the host pipe descriptor: register port, size
 * decode, zero-length handling, byte accounting, flags and error tally.
 * Assumes the device model answers with one-cycle event pulses.
 */
module test_usb_host_pipe_descriptor;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys_in, rst_in, reg_wr, reg_rd, bank_sel, pipe_in, ev_go;
    logic [4:0] reg_addr;
    logic [31:0] reg_wdata, rdata;
    logic [3:0] pulse_v, ev_code, ep, sub;
    logic [13:0] val, mps, bcnt;
    logic [8:0] ev;
    logic [10:0] max_len, var_f;
    logic azlp, zlp, frozen;
    logic [6:0] dev_addr;
    logic [2:0] tally;
    int bad_count, check_count;
    usb_dev_model usb_dev_model_inst (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
        .ev_go_in(ev_go), .ev_code_in(ev_code), .ev_out(ev));
    usb_host_pipe_descriptor usb_host_pipe_descriptor_inst (.clk_sys_in(clk_sys_in),
        .rst_in(rst_in), .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
        .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(rdata),
        .bank_sel_in(bank_sel), .pipe_is_in_in(pipe_in), .usb_reset_sent_in(pulse_v[0]),
        .xfer_done_in(pulse_v[1]), .mps_add_in(pulse_v[2]), .mps_add_val_in(val),
        .byte_cnt_upd_in(pulse_v[3]), .byte_cnt_val_in(val), .nak_in(ev[5]),
        .iso_overrun_in(ev[6]), .iso_underflow_in(ev[7]), .iso_crc_in(ev[8]),
        .crc16_in(ev[4]), .timeout_in(ev[3]), .pid_in(ev[2]), .dpid_in(ev[1]),
        .toggle_in(ev[0]), .max_len_out(max_len), .auto_zero_len_handshake_out(azlp),
        .zlp_send_out(zlp), .mps_out(mps), .byte_cnt_out(bcnt),
        .target_device_address_out(dev_addr), .target_endpoint_number_out(ep),
        .ext_variable_out(var_f), .ext_token_subtype_out(sub),
        .pipe_frozen_out(frozen), .pipe_error_tally_out(tally));
    // Clock at 125 MHz
    initial begin
        clk_sys_in = 1'b0;
        forever #4 clk_sys_in = ~clk_sys_in;
    end
    // Verdict and end of run
    task automatic final_report();
        if (bad_count == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            $display("mismatch %s expected %h seen %h", n, e, g);
            bad_count++;
        end
    endtask
    // Register port: one-cycle strobes, read data in the next cycle only
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge clk_sys_in);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys_in);
        reg_wr <= 1'b0;
    endtask
    task automatic rdc(input logic [4:0] a, input logic [31:0] e);
        @(posedge clk_sys_in);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys_in);
        reg_rd <= 1'b0;
        #1 chk($sformatf("read %h", a), e, rdata);
    endtask
    // Engine pulse straight from the bench, visible after the taking edge
    task automatic pulse(input int w, input logic [13:0] v);
        @(posedge clk_sys_in);
        pulse_v <= 4'h1 << w;
        val <= v;
        @(posedge clk_sys_in);
        pulse_v <= 4'h0;
        #1;
    endtask
    // Device answer through the model, one cycle later than a direct pulse
    task automatic dev(input logic [3:0] c);
        @(posedge clk_sys_in);
        ev_go <= 1'b1;
        ev_code <= c;
        @(posedge clk_sys_in);
        ev_go <= 1'b0;
        @(posedge clk_sys_in);
        #1;
    endtask
    task automatic t_reset();
        chk("max_len", 32'h0000_0008, 32'(max_len));
        rdc(5'h0C, 32'h0000_0000);
        #8 chk("rdata idle", 32'h0000_0000, rdata);
        wr(5'h00, 32'hFFFF_FFFC);
        rdc(5'h00, 32'h0000_0000);
    endtask
    task automatic t_size();
        // Codes 4 and up stand for isochronous pipes here
        for (int c = 0; c < 8; c++) begin
            wr(5'h04, 32'(c) << 28);
            @(posedge clk_sys_in);
            #1 chk("max_len", c == 7 ? 32'd1023 : 32'd8 << c, 32'(max_len));
        end
        pulse(0, 14'h0000);
        rdc(5'h04, 32'h0000_0000);
        chk("max_len", 32'h0000_0008, 32'(max_len));
    endtask
    task automatic t_zlp();
        @(posedge clk_sys_in) pipe_in <= 1'b0;
        wr(5'h04, 32'h8000_0000);
        #1 chk("auto_zero_len_handshake", 32'h1, 32'(azlp));
        pulse(1, 14'h0000);
        chk("zlp send", 32'h1, 32'(zlp));
        #8 chk("zlp send", 32'h0, 32'(zlp));
        @(posedge clk_sys_in) pipe_in <= 1'b1;
        pulse(1, 14'h0000);
        chk("auto_zero_len_handshake", 32'h0, 32'(azlp));
        chk("zlp send", 32'h0, 32'(zlp));
    endtask
    task automatic t_count();
        @(posedge clk_sys_in) bank_sel <= 1'b1;
        wr(5'h14, 32'h0000_0000);
        pulse(2, 14'h0040);
        pulse(2, 14'h0040);
        chk("mps", 32'h0080, 32'(mps));
        @(posedge clk_sys_in) pipe_in <= 1'b0;
        pulse(2, 14'h0040);
        chk("mps", 32'h0080, 32'(mps));
        wr(5'h14, 32'h3000_0000 | 32'h0080 << 14);
        pulse(3, 14'h0011);
        chk("byte count", 32'h0011, 32'(bcnt));
        rdc(5'h14, 32'h3020_0011);
        rdc(5'h04, 32'h8000_0000);
    endtask
    task automatic t_words();
        wr(5'h08, 32'h0000_FFFF);
        rdc(5'h08, 32'h0000_7FFF);
        // Latency 5, wake allowed, link state 1, reserved bits zero
        wr(5'h08, 32'h0000_1513);
        rdc(5'h08, 32'h0000_1513);
        chk("variable", 32'h0151, 32'(var_f));
        chk("subtype", 32'h0003, 32'(sub));
        wr(5'h0C, 32'h0000_3AD5);
        rdc(5'h0C, 32'h0000_3A55);
        chk("address", 32'h0055, 32'(dev_addr));
        chk("endpoint", 32'h000A, 32'(ep));
    endtask
    task automatic t_bank();
        // NAK, overrun, underflow on alternating banks
        for (int i = 5; i < 8; i++) begin
            @(posedge clk_sys_in) bank_sel <= i[0];
            dev(4'(i));
            rdc(i[0] ? 5'h1A : 5'h0A, 32'h0000_0002);
            rdc(i[0] ? 5'h0A : 5'h1A, 32'h0000_0000);
            wr(i[0] ? 5'h1A : 5'h0A, 32'h0000_0000);
        end
        @(posedge clk_sys_in) pipe_in <= 1'b0;
        dev(4'h8);
        rdc(5'h1A, 32'h0000_0000);
        @(posedge clk_sys_in) pipe_in <= 1'b1;
        dev(4'h8);
        rdc(5'h1A, 32'h0000_0001);
    endtask
    task automatic t_pipe();
        logic [4:0] fl;
        fl = 5'h00;
        @(posedge clk_sys_in) pipe_in <= 1'b0;
        dev(4'h4);
        rdc(5'h0E, 32'h0000_0000);
        @(posedge clk_sys_in) pipe_in <= 1'b1;
        // Toggle, data id, id, timeout, CRC16; limit is 3
        for (int i = 0; i < 5; i++) begin
            dev(4'(i));
            fl[i] = 1'b1;
            rdc(5'h0E, 32'(i + 1) << 5 | 32'(fl));
            chk("frozen", 32'(i >= 2), 32'(frozen));
        end
        repeat (3) dev(4'h0);
        chk("tally", 32'h7, 32'(tally));
        wr(5'h0E, 32'h0000_0000);
        rdc(5'h0E, 32'h0000_00E0);
        wr(5'h0C, 32'h0000_0000);
        rdc(5'h0E, 32'h0000_0000);
        chk("frozen", 32'h0, 32'(frozen));
    endtask
    // Bound on the whole run
    initial begin
        repeat (20000) @(posedge clk_sys_in);
        bad_count++;
        final_report();
    end
    initial begin
        bad_count = 0;
        check_count = 0;
        rst_in = 1'b1;
        {reg_wr, reg_rd, bank_sel, pipe_in, ev_go} = 5'h00;
        {reg_addr, reg_wdata, pulse_v, val, ev_code} = '0;
        repeat (8) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        #1;
        t_reset();
        t_size();
        t_zlp();
        t_count();
        t_words();
        t_bank();
        t_pipe();
        final_report();
    end
endmodule

// ---- usb_dev_model.sv ----
/*
 * Model of the attached USB device: turns a coded request from the bench
 * into one-cycle handshake and error pulses at the engine event inputs.
 * Assumes one request at a time, launched on the system clock.
 */
module usb_dev_model (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_in,
    // Request from the bench
    input wire logic ev_go_in,
    input wire logic [3:0] ev_code_in,
    // Event pulses, one bit per kind
    output logic [8:0] ev_out
);
    // One cycle only, so the block never sees an event twice
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            ev_out <= 9'h000;
        end else begin
            ev_out <= ev_go_in ? 9'h001 << ev_code_in : 9'h000;
        end
    end
endmodule

// ---- usb_host_pipe_descriptor.sv ----
/*
 * One host pipe descriptor: two packet size banks, extended token word,
 * control word, bank and pipe status, error tally and freeze logic.
 * Assumes the transaction engine runs on the same clock, gives single
 * cycle event pulses for the bank on bank_sel_in, and that software
 * keeps size codes, transfer totals and buffer alignment legal.
 */
// Chosen here: strobed register access.
module usb_host_pipe_descriptor (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_in,
    // Register port
    input wire logic [4:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [31:0] reg_rdata_out,
    // Engine context
    input wire logic bank_sel_in,
    input wire logic pipe_is_in_in,
    input wire logic usb_reset_sent_in,
    input wire logic xfer_done_in,
    // Engine byte accounting
    input wire logic mps_add_in,
    input wire logic [13:0] mps_add_val_in,
    input wire logic byte_cnt_upd_in,
    input wire logic [13:0] byte_cnt_val_in,
    // Engine events
    input wire logic nak_in,
    input wire logic iso_overrun_in,
    input wire logic iso_underflow_in,
    input wire logic iso_crc_in,
    input wire logic crc16_in,
    input wire logic timeout_in,
    input wire logic pid_in,
    input wire logic dpid_in,
    input wire logic toggle_in,
    // Descriptor fields for the engine
    output logic [10:0] max_len_out,
    output logic auto_zero_len_handshake_out,
    output logic zlp_send_out,
    output logic [13:0] mps_out,
    output logic [13:0] byte_cnt_out,
    output logic [6:0] target_device_address_out,
    output logic [3:0] target_endpoint_number_out,
    output logic [10:0] ext_variable_out,
    output logic [3:0] ext_token_subtype_out,
    output logic pipe_frozen_out,
    output logic [2:0] pipe_error_tally_out
);

    logic [31:0] pck_q [2];
    logic [14:0] ext_q;
    logic [15:0] ctrl_q;
    logic [2:0] tally_q;
    logic frozen_q;
    logic zlp_q;
    logic [31:0] rdata_q;
    logic [1:0] bank_flags [2];
    logic [4:0] pipe_flags;
    logic [4:0] pipe_set;
    logic pipe_err;
    logic [3:0] limit;
    logic [3:0] tally_next;
    logic ctrl_wr;
    logic [31:0] pck_sel;

    assign pck_sel = pck_q[bank_sel_in];
    assign ctrl_wr = reg_wr_in && (reg_addr_in == pipe_desc_pkg::OFS_CTRL);
    assign limit = ctrl_q[pipe_desc_pkg::LIMIT_LSB +: 4];

    // Packet size words; engine updates beat a software write
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            pck_q[0] <= pipe_desc_pkg::PCK_RST;
            pck_q[1] <= pipe_desc_pkg::PCK_RST;
        end else begin
            for (int b = 0; b < 2; b++) begin
                if (reg_wr_in && reg_addr_in == (b == 1 ? pipe_desc_pkg::OFS_PCK_BANK1
                                                        : pipe_desc_pkg::OFS_PCK_BANK0)) begin
                    pck_q[b] <= reg_wdata_in;
                end
                if (bank_sel_in == 1'(b)) begin
                    if (mps_add_in && pipe_is_in_in) begin
                        pck_q[b][pipe_desc_pkg::MPS_LSB +: 14] <=
                            pck_q[b][pipe_desc_pkg::MPS_LSB +: 14] + mps_add_val_in;
                    end
                    if (byte_cnt_upd_in) begin
                        pck_q[b][pipe_desc_pkg::BCNT_LSB +: 14] <= byte_cnt_val_in;
                    end
                end
                if (usb_reset_sent_in) begin
                    pck_q[b][pipe_desc_pkg::SIZE_LSB +: 3] <= 3'h0;
                end
            end
        end
    end

    // Extended token word; bit 15 is reserved and reads zero
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            ext_q <= pipe_desc_pkg::EXT_RST;
        end else if (reg_wr_in && reg_addr_in == pipe_desc_pkg::OFS_EXT) begin
            ext_q <= reg_wdata_in[14:0];
        end
    end

    // Control word; bit 7 is reserved
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            ctrl_q <= pipe_desc_pkg::CTRL_RST;
        end else if (ctrl_wr) begin
            ctrl_q <= reg_wdata_in[15:0] & 16'hFF7F;
        end
    end

    // Bank flags; the event lands in the bank the engine works on
    for (genvar b = 0; b < 2; b++) begin : g_bank
        logic [1:0] bank_set;
        logic bank_wr;
        assign bank_set[pipe_desc_pkg::FLOW_BIT] = (bank_sel_in == 1'(b)) &&
            (nak_in || iso_overrun_in || iso_underflow_in);
        assign bank_set[pipe_desc_pkg::BCRC_BIT] = (bank_sel_in == 1'(b)) &&
            iso_crc_in && pipe_is_in_in;
        assign bank_wr = reg_wr_in && reg_addr_in == (b == 1 ? pipe_desc_pkg::OFS_BSTAT_BANK1
                                                             : pipe_desc_pkg::OFS_BSTAT_BANK0);
        fault_flag_bits #(
            .WIDTH(2)
        ) u_bank_flags (
            .clk_sys_in(clk_sys_in),
            .rst_in(rst_in),
            .set_in(bank_set),
            .wr_in(bank_wr),
            .wr_val_in(reg_wdata_in[1:0]),
            .flags_out(bank_flags[b])
        );
    end

    // Pipe error flags
    assign pipe_set[pipe_desc_pkg::CRC16_BIT] = crc16_in && pipe_is_in_in;
    assign pipe_set[pipe_desc_pkg::TOUT_BIT] = timeout_in;
    assign pipe_set[pipe_desc_pkg::PID_BIT] = pid_in;
    assign pipe_set[pipe_desc_pkg::DPID_BIT] = dpid_in;
    assign pipe_set[pipe_desc_pkg::TOGGLE_BIT] = toggle_in;
    assign pipe_err = |pipe_set;

    // Read-only bits 4:3 clear on write, bits 2:0 take the written value
    fault_flag_bits #(
        .WIDTH(5)
    ) u_pipe_flags (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .set_in(pipe_set),
        .wr_in(reg_wr_in && reg_addr_in == pipe_desc_pkg::OFS_PSTAT),
        .wr_val_in({2'b00, reg_wdata_in[2:0]}),
        .flags_out(pipe_flags)
    );

    // Tally saturates so it cannot wrap back under the limit
    assign tally_next = (tally_q == pipe_desc_pkg::TALLY_MAX) ? {1'b0, tally_q}
                                                              : {1'b0, tally_q} + 4'h1;

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            tally_q <= 3'h0;
        end else if (pipe_err) begin
            tally_q <= tally_next[2:0];
        end else if (ctrl_wr) begin
            tally_q <= 3'h0;
        end
    end

    // Freeze once the tally reaches a nonzero limit; a control write thaws
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            frozen_q <= 1'b0;
        end else if (pipe_err && limit != 4'h0 && tally_next >= limit) begin
            frozen_q <= 1'b1;
        end else if (ctrl_wr) begin
            frozen_q <= 1'b0;
        end
    end

    // Zero length packet sent by hardware at the end of an OUT transfer
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            zlp_q <= 1'b0;
        end else begin
            zlp_q <= xfer_done_in && !pipe_is_in_in && pck_sel[pipe_desc_pkg::AZLP_BIT];
        end
    end

    pipe_size_decode u_size (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .size_code_in(pck_sel[pipe_desc_pkg::SIZE_LSB +: 3]),
        .max_len_out(max_len_out)
    );

    // Read data stand for one cycle only; unmapped offsets read zero
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_q <= 32'h0000_0000;
        end else if (!reg_rd_in) begin
            rdata_q <= 32'h0000_0000;
        end else begin
            unique case (reg_addr_in)
                pipe_desc_pkg::OFS_PCK_BANK0: rdata_q <= pck_q[0];
                pipe_desc_pkg::OFS_PCK_BANK1: rdata_q <= pck_q[1];
                pipe_desc_pkg::OFS_EXT: rdata_q <= {17'h00000, ext_q};
                pipe_desc_pkg::OFS_BSTAT_BANK0: rdata_q <= {30'h0000_0000, bank_flags[0]};
                pipe_desc_pkg::OFS_BSTAT_BANK1: rdata_q <= {30'h0000_0000, bank_flags[1]};
                pipe_desc_pkg::OFS_CTRL: rdata_q <= {16'h0000, ctrl_q};
                pipe_desc_pkg::OFS_PSTAT: rdata_q <= {24'h000000, tally_q, pipe_flags};
                default: rdata_q <= 32'h0000_0000;
            endcase
        end
    end

    // Read data and outputs toward the engine
    assign reg_rdata_out = rdata_q;
    assign auto_zero_len_handshake_out = pck_sel[pipe_desc_pkg::AZLP_BIT] && !pipe_is_in_in;
    assign zlp_send_out = zlp_q;
    assign mps_out = pck_sel[pipe_desc_pkg::MPS_LSB +: 14];
    assign byte_cnt_out = pck_sel[pipe_desc_pkg::BCNT_LSB +: 14];
    assign target_device_address_out = ctrl_q[pipe_desc_pkg::ADDR_LSB +: 7];
    assign target_endpoint_number_out = ctrl_q[pipe_desc_pkg::EP_LSB +: 4];
    assign ext_variable_out = ext_q[pipe_desc_pkg::VAR_LSB +: 11];
    assign ext_token_subtype_out = ext_q[pipe_desc_pkg::SUBTYPE_LSB +: 4];
    assign pipe_frozen_out = frozen_q;
    assign pipe_error_tally_out = tally_q;

    // Steps for the size decode check
    sequence s_top_code_held;
        pck_sel[30:28] == 3'h7 && !usb_reset_sent_in ##1
        pck_sel[30:28] == 3'h7;
    endsequence

    // Steps for the freeze check
    sequence s_error_at_limit;
        pipe_err && limit != 4'h0 && ({1'b0, tally_q} + 4'h1) >= limit
            && tally_q != 3'h7;
    endsequence

    a_size_full_speed: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        s_top_code_held |=> max_len_out == 11'h3FF)
        else $error("max length not 1023 for top size code");

    a_size_bus_reset: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        usb_reset_sent_in |=> pck_q[0][30:28] == 3'h0 && pck_q[1][30:28] == 3'h0)
        else $error("size field survived a bus reset");

    a_mps_accumulate: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        mps_add_in && pipe_is_in_in && !reg_wr_in
        |=> mps_out == 14'($past(mps_out) + $past(mps_add_val_in)) || $changed(bank_sel_in))
        else $error("multi-packet size did not accumulate");

    a_byte_count_load: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        byte_cnt_upd_in ##1 $stable(bank_sel_in) |-> byte_cnt_out == $past(byte_cnt_val_in))
        else $error("byte count not loaded");

    a_flow_fault_set: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        (nak_in || iso_overrun_in || iso_underflow_in)
        |=> bank_flags[$past(bank_sel_in)][1])
        else $error("flow fault flag not set");

    a_bank_crc_set: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        iso_crc_in && pipe_is_in_in |=> bank_flags[$past(bank_sel_in)][0])
        else $error("bank crc flag not set");

    a_pipe_flags_set: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        pipe_set != 5'h00 |=> (pipe_flags & $past(pipe_set)) == $past(pipe_set))
        else $error("pipe error flag lost");

    a_tally_count: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        pipe_err && tally_q != 3'h7 |=> tally_q == 3'($past(tally_q) + 3'h1))
        else $error("error tally did not count");

    a_freeze_limit: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        s_error_at_limit |=> pipe_frozen_out ##1 (pipe_frozen_out || $past(ctrl_wr)))
        else $error("pipe not frozen at error limit");

    a_zlp_out_only: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        xfer_done_in && !pipe_is_in_in && auto_zero_len_handshake_out
        |=> zlp_send_out ##1 !zlp_send_out || $past(xfer_done_in))
        else $error("zero length packet request wrong");

    a_read_ctrl: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        reg_rd_in && reg_addr_in == 5'h0C && !reg_wr_in
        |=> reg_rdata_out[6:0] == target_device_address_out)
        else $error("control word read mismatch");

    // Field loads, holding and limit checks
    a_size_mid_code: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        pck_sel[30:28] == 3'h3 |=> max_len_out == 11'h040)
        else $error("max length not 64 for size code 3");

    a_zlp_needs_auto: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        !(xfer_done_in && auto_zero_len_handshake_out) |=> !zlp_send_out)
        else $error("zero length packet request without auto mode");

    a_ext_fields: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        reg_wr_in && reg_addr_in == 5'h08 |=> ext_variable_out == $past(reg_wdata_in[14:4])
            && ext_token_subtype_out == $past(reg_wdata_in[3:0]))
        else $error("extended token fields not loaded");

    a_ctrl_fields: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        ctrl_wr |=> target_device_address_out == $past(reg_wdata_in[6:0])
            && target_endpoint_number_out == $past(reg_wdata_in[11:8]))
        else $error("address or endpoint not loaded");

    a_tally_clear: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        ctrl_wr && !pipe_err |=> tally_q == 3'h0)
        else $error("error tally not cleared by control write");

    a_flags_sticky: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        !(reg_wr_in && reg_addr_in == 5'h0E)
        |=> (pipe_flags & $past(pipe_flags)) == $past(pipe_flags))
        else $error("pipe error flag dropped without a write");

    a_freeze_hold: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        pipe_frozen_out && !ctrl_wr |=> pipe_frozen_out)
        else $error("pipe thawed without a control write");

    a_limit_zero: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        limit == 4'h0 && !pipe_frozen_out |=> !pipe_frozen_out)
        else $error("pipe frozen with a zero error limit");

endmodule
